// ===== rtl/mpt_pkg.sv
package mpt_pkg;
    localparam int CNT_W = 16;
    localparam int NCH = 8;
    localparam int NPAIR = 4;
    localparam int NFLT = 4;
    localparam int DT_W = 6;
    localparam int FCNT_W = 4;
    localparam int DIV_W = 7;
    localparam int NFILT_CH = 4;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] FREE_FINAL = 16'hFFFF;
    localparam logic [15:0] FREE_INIT = 16'h0000;
    localparam logic [15:0] CNT_STEP = 16'h0001;
    localparam logic [5:0] DT_STEP = 6'h01;
    localparam logic [3:0] FCNT_STEP = 4'h1;
    localparam logic [6:0] DIV_STEP = 7'h01;
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [1:0] SRC_SYS = 2'h1;
    localparam logic [1:0] SRC_FIXED = 2'h2;
    localparam logic [1:0] SRC_EXT = 2'h3;
    localparam logic [1:0] MODE_CAPT = 2'h0;
    localparam logic [1:0] MODE_CMP = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] ACT_CLR = 2'h1;
    localparam logic [1:0] ACT_SET = 2'h2;
    localparam logic [1:0] ACT_TOG = 2'h3;
    localparam logic [1:0] FLT_OFF = 2'h0;
    localparam logic [1:0] FLT_AUTO = 2'h3;
    typedef enum logic {DIR_UP, DIR_DOWN} mpt_dir_t;
endpackage

// ===== rtl/mpt_chan_if.sv
`timescale 1ns/1ns
interface mpt_chan_if;
    logic [15:0] cnt;
    logic tick;
    logic [1:0] mode;
    logic [1:0] edge_sel;
    logic [15:0] value;
    logic filt_en;
    logic [3:0] filt_len;
    logic pin_i;
    logic out;
    logic [15:0] capt;
    logic ev;
    modport core (output cnt, tick, mode, edge_sel, value, filt_en, filt_len, pin_i,
        input out, capt, ev);
    modport chan (input cnt, tick, mode, edge_sel, value, filt_en, filt_len, pin_i,
        output out, capt, ev);
endinterface

// ===== rtl/mpt_prescaler.sv
`timescale 1ns/1ns
module mpt_prescaler (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Source and division
    input wire logic [1:0] src,
    input wire logic fixed_tick,
    input wire logic ext_count_clock,
    input wire logic [2:0] ps,
    input wire logic halt,
    // Counter enable
    output logic tick
);
    typedef struct packed {
        logic ext_q;
        logic ext_p;
        logic [6:0] div;
    } mpt_ps_st_t;
    mpt_ps_st_t s_q;
    mpt_ps_st_t s_d;
    logic base;
    logic [6:0] mask;

    always_comb begin
        s_d = s_q;
        s_d.ext_q = ext_count_clock;
        s_d.ext_p = s_q.ext_q;
        mask = 7'((8'h01 << ps) - 8'h01);
        case (src)
            mpt_pkg::SRC_SYS: base = 1'b1;
            mpt_pkg::SRC_FIXED: base = fixed_tick;
            mpt_pkg::SRC_EXT: base = s_q.ext_q & ~s_q.ext_p;
            default: base = 1'b0;
        endcase
        base = base & ~halt;
        tick = base && ((s_q.div & mask) == mask);
        if (base) begin
            s_d.div = s_q.div + mpt_pkg::DIV_STEP;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_ext_edge_src: assert property (
        (src == mpt_pkg::SRC_EXT && tick) |-> $past(ext_count_clock) && !$past(ext_count_clock, 2))
        else $error("external tick without a rising edge");
    a_div_two_ratio: assert property (
        (src == mpt_pkg::SRC_SYS && ps == 3'h1 && !halt && tick) |=> !tick)
        else $error("divide by two ticked twice in a row");
    a_halt_no_tick: assert property (
        halt |-> !tick)
        else $error("tick while clocks are stopped");
endmodule // mpt_prescaler

// ===== rtl/mpt_channel.sv
`timescale 1ns/1ns
module mpt_channel #(
    parameter bit HAS_FILTER = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Channel link
    mpt_chan_if.chan b
);
    typedef struct packed {
        logic pin;
        logic filt;
        logic [3:0] fcnt;
        logic out;
        logic [15:0] capt;
        logic ev;
    } mpt_ch_st_t;
    mpt_ch_st_t s_q;
    mpt_ch_st_t s_d;
    logic rise;
    logic fall;
    logic hit;

    always_comb begin
        s_d = s_q;
        s_d.ev = 1'b0;
        s_d.pin = b.pin_i;
        // filter bits are inert where no filter exists
        if (HAS_FILTER && b.filt_en) begin
            if (s_q.pin == s_q.filt) begin
                s_d.fcnt = '0;
            end else if (s_q.fcnt >= b.filt_len) begin
                s_d.filt = s_q.pin;
                s_d.fcnt = '0;
            end else begin
                s_d.fcnt = s_q.fcnt + mpt_pkg::FCNT_STEP;
            end
        end else begin
            s_d.filt = s_q.pin;
            s_d.fcnt = '0;
        end
        rise = s_d.filt & ~s_q.filt;
        fall = ~s_d.filt & s_q.filt;
        hit = b.tick && (b.cnt == b.value);
        case (b.mode)
            mpt_pkg::MODE_CAPT: begin
                if ((rise && b.edge_sel[0]) || (fall && b.edge_sel[1])) begin
                    s_d.capt = b.cnt;
                    s_d.ev = 1'b1;
                end
            end
            mpt_pkg::MODE_CMP: begin
                // set, clear or toggle on match
                if (hit) begin
                    s_d.ev = 1'b1;
                    case (b.edge_sel)
                        mpt_pkg::ACT_CLR: s_d.out = 1'b0;
                        mpt_pkg::ACT_SET: s_d.out = 1'b1;
                        mpt_pkg::ACT_TOG: s_d.out = ~s_q.out;
                        default: s_d.out = s_q.out;
                    endcase
                end
            end
            mpt_pkg::MODE_PWM: begin
                // level compare is symmetric under up-down counting
                s_d.out = (b.cnt < b.value) ^ b.edge_sel[0];
                s_d.ev = hit;
            end
            default: s_d.out = s_q.out;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign b.out = s_q.out;
    assign b.capt = s_q.capt;
    assign b.ev = s_q.ev;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_capture_rise_val: assert property (
        (b.mode == mpt_pkg::MODE_CAPT && b.edge_sel[0] && rise) |=>
        (b.capt == $past(b.cnt)) && b.ev)
        else $error("rising edge not captured");
    a_compare_toggle_out: assert property (
        (b.mode == mpt_pkg::MODE_CMP && b.edge_sel == mpt_pkg::ACT_TOG && hit) |=>
        (b.out != $past(b.out)))
        else $error("compare toggle missed");
endmodule // mpt_channel

// ===== rtl/mpt_motor_pwm_timer.sv
`timescale 1ns/1ns
module mpt_motor_pwm_timer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Counter clocking
    input wire logic [1:0] clock_source_select,
    input wire logic fixed_freq_tick,
    input wire logic ext_count_clock,
    input wire logic [2:0] prescale_select,
    input wire logic debug_halt,
    input wire logic stop_mode,
    // Protected configuration, taken on crit_write
    input wire logic crit_write,
    input wire logic protect_set,
    input wire logic protect_clear,
    input wire logic up_down_count,
    input wire logic free_run,
    input wire logic [7:0][1:0] ch_mode,
    input wire logic [7:0][1:0] ch_edge,
    input wire logic [3:0] pair_link_control,
    input wire logic [3:0] pair_complement,
    input wire logic [3:0] pair_deadtime_en,
    input wire logic [5:0] deadtime_cycles,
    input wire logic [3:0] pair_fault_enable,
    input wire logic [1:0] fault_handling_mode,
    input wire logic [3:0] fault_input_enable,
    // Buffered values
    input wire logic buf_write,
    input wire logic [15:0] counter_initial_value,
    input wire logic [15:0] final_value,
    input wire logic [7:0][15:0] ch_value,
    input wire logic sync_trigger,
    input wire logic pwm_reload_control,
    // Output shaping and input filters
    input wire logic enhanced_feature_enable,
    input wire logic [7:0] polarity,
    input wire logic [7:0] output_mask,
    input wire logic [7:0] force_en,
    input wire logic [7:0] force_val,
    input wire logic [7:0] filter_en,
    input wire logic [3:0] filter_len,
    // Flags
    input wire logic [7:0] ch_flag_clr,
    input wire logic ovf_clr,
    input wire logic fault_clr,
    output logic [7:0] ch_flag,
    output logic ovf_flag,
    output logic fault_flag,
    output logic protect_active,
    // Pins
    input wire logic [7:0] channel_pin_i,
    output logic [7:0] channel_pin_o,
    output logic [7:0] channel_pin_oe,
    input wire logic [3:0] fault_input,
    // Observation
    output logic [15:0] count_value,
    output logic [7:0][15:0] capture_value
);
    typedef struct packed {
        logic [15:0] cnt;
        mpt_pkg::mpt_dir_t dir;
        logic [15:0] init_a;
        logic [15:0] fin_a;
        logic [7:0][15:0] val_a;
        logic [15:0] init_b;
        logic [15:0] fin_b;
        logic [7:0][15:0] val_b;
        logic wp;
        logic updown;
        logic free;
        logic [7:0][1:0] mode;
        logic [7:0][1:0] esel;
        logic [3:0] comb;
        logic [3:0] comp;
        logic [3:0] dten;
        logic [5:0] dtc;
        logic [3:0] pfen;
        logic [1:0] fmode;
        logic [3:0] fien;
        logic [7:0] chf;
        logic ovf;
        logic fltf;
        logic flat;
        logic [3:0][5:0] dt;
        logic [3:0] prev;
        logic [7:0] pin_o;
        logic [7:0] pin_oe;
    } mpt_top_st_t;
    mpt_top_st_t s_q;
    mpt_top_st_t s_d;
    logic tick_w;
    logic [15:0] fin_w;
    logic [15:0] ini_w;
    logic reload_w;
    logic load_w;
    logic ovf_set_w;
    logic flt_in_w;
    logic [7:0] raw_w;
    logic [7:0] ev_w;
    mpt_chan_if chi[8] ();

    // debug halt and stop both gate the counter source
    mpt_prescaler u_ps (
        .clk_sys(clk_sys),
        .reset(reset),
        .src(clock_source_select),
        .fixed_tick(fixed_freq_tick),
        .ext_count_clock(ext_count_clock),
        .ps(prescale_select),
        .halt(debug_halt | stop_mode),
        .tick(tick_w)
    );

    genvar g;
    for (g = 0; g < mpt_pkg::NCH; g++) begin : g_ch
        assign chi[g].cnt = s_q.cnt;
        assign chi[g].tick = tick_w;
        assign chi[g].mode = s_q.mode[g];
        assign chi[g].edge_sel = s_q.esel[g];
        assign chi[g].value = s_q.val_a[g];
        assign chi[g].filt_en = filter_en[g];
        assign chi[g].filt_len = filter_len;
        assign chi[g].pin_i = channel_pin_i[g];
        assign raw_w[g] = chi[g].out;
        assign ev_w[g] = chi[g].ev;
        assign capture_value[g] = chi[g].capt;
        mpt_channel #(.HAS_FILTER(g < mpt_pkg::NFILT_CH)) u_ch (
            .clk_sys(clk_sys),
            .reset(reset),
            .b(chi[g])
        );
    end

    // free running spans the whole range
    assign fin_w = s_q.free ? mpt_pkg::FREE_FINAL : s_q.fin_a;
    assign ini_w = s_q.free ? mpt_pkg::FREE_INIT : s_q.init_a;
    assign reload_w = tick_w && (s_q.updown ? (s_q.dir == mpt_pkg::DIR_DOWN
        && s_q.cnt == ini_w) : (s_q.cnt == fin_w));
    assign ovf_set_w = tick_w && s_q.cnt == fin_w && (!s_q.updown || s_q.dir == mpt_pkg::DIR_UP);
    // transfer at the sync trigger or at the reload point
    assign load_w = sync_trigger | (pwm_reload_control & reload_w);
    // each fault input has its own enable
    assign flt_in_w = enhanced_feature_enable && |(fault_input & s_q.fien);

    always_comb begin
        logic pe;
        logic po;
        logic blank;
        logic cmb;
        logic cmp;
        logic [7:0] lvl;
        logic [7:0] safe;
        pe = 1'b0;
        po = 1'b0;
        blank = 1'b0;
        cmb = 1'b0;
        cmp = 1'b0;
        lvl = '0;
        safe = '0;
        s_d = s_q;
        if (tick_w) begin
            if (!s_q.updown) begin
                // final value wraps to the initial value
                if (s_q.cnt == fin_w) begin
                    s_d.cnt = ini_w;
                end else begin
                    s_d.cnt = s_q.cnt + mpt_pkg::CNT_STEP;
                end
            end else if (s_q.dir == mpt_pkg::DIR_UP) begin
                if (s_q.cnt == fin_w) begin
                    s_d.dir = mpt_pkg::DIR_DOWN;
                    s_d.cnt = s_q.cnt - mpt_pkg::CNT_STEP;
                end else begin
                    s_d.cnt = s_q.cnt + mpt_pkg::CNT_STEP;
                end
            end else begin
                if (s_q.cnt == ini_w) begin
                    s_d.dir = mpt_pkg::DIR_UP;
                    s_d.cnt = s_q.cnt + mpt_pkg::CNT_STEP;
                end else begin
                    s_d.cnt = s_q.cnt - mpt_pkg::CNT_STEP;
                end
            end
        end
        // software writes land in the buffer only
        if (buf_write) begin
            s_d.init_b = counter_initial_value;
            s_d.fin_b = final_value;
            s_d.val_b = ch_value;
        end
        if (load_w) begin
            s_d.init_a = s_q.init_b;
            s_d.fin_a = s_q.fin_b;
            s_d.val_a = s_q.val_b;
        end
        if (protect_set) begin
            s_d.wp = 1'b1;
        end else if (protect_clear) begin
            s_d.wp = 1'b0;
        end
        if (crit_write && !s_q.wp) begin
            s_d.updown = up_down_count;
            s_d.free = free_run;
            s_d.mode = ch_mode;
            s_d.esel = ch_edge;
            s_d.comb = pair_link_control;
            s_d.comp = pair_complement;
            s_d.dten = pair_deadtime_en;
            s_d.dtc = deadtime_cycles;
            s_d.pfen = pair_fault_enable;
            s_d.fmode = fault_handling_mode;
            s_d.fien = fault_input_enable;
        end
        // sticky event flags, set beats clear
        s_d.chf = ev_w | (s_q.chf & ~ch_flag_clr);
        s_d.ovf = ovf_set_w | (s_q.ovf & ~ovf_clr);
        s_d.fltf = flt_in_w | (s_q.fltf & ~fault_clr);
        // manual modes hold until cleared with the input gone
        case (s_q.fmode)
            mpt_pkg::FLT_OFF: s_d.flat = 1'b0;
            mpt_pkg::FLT_AUTO: s_d.flat = flt_in_w;
            default: s_d.flat = flt_in_w | (s_q.flat & ~fault_clr);
        endcase
        for (int p = 0; p < mpt_pkg::NPAIR; p++) begin
            // pair features need the enhanced enable
            cmb = enhanced_feature_enable & s_q.comb[p];
            cmp = enhanced_feature_enable & s_q.comp[p];
            // lead edge at even value, trail edge at odd value
            if (cmb) begin
                pe = s_q.cnt >= s_q.val_a[2*p] && s_q.cnt < s_q.val_a[2*p+1];
            end else begin
                pe = raw_w[2*p];
            end
            po = cmp ? ~pe : (cmb ? pe : raw_w[2*p+1]);
            s_d.prev[p] = pe;
            blank = 1'b0;
            s_d.dt[p] = s_q.dt[p];
            // deadtime blanks both outputs after each switch
            if (cmp && s_q.dten[p]) begin
                if (pe != s_q.prev[p] && s_q.dtc != '0) begin
                    s_d.dt[p] = s_q.dtc - mpt_pkg::DT_STEP;
                    blank = 1'b1;
                end else if (s_q.dt[p] != '0) begin
                    s_d.dt[p] = s_q.dt[p] - mpt_pkg::DT_STEP;
                    blank = 1'b1;
                end
            end
            lvl[2*p] = pe & ~blank;
            lvl[2*p+1] = po & ~blank;
            safe[2*p] = enhanced_feature_enable & s_q.flat & s_q.pfen[p];
            safe[2*p+1] = safe[2*p];
            s_d.pin_oe[2*p] = s_q.mode[2*p] != mpt_pkg::MODE_CAPT || cmb;
            s_d.pin_oe[2*p+1] = s_q.mode[2*p+1] != mpt_pkg::MODE_CAPT || cmb;
        end
        for (int c = 0; c < mpt_pkg::NCH; c++) begin
            // force, mask and polarity only with enhancements on
            if (enhanced_feature_enable && force_en[c]) begin
                lvl[c] = force_val[c];
            end
            // safe level is the inactive polarity
            if (safe[c] || (enhanced_feature_enable && output_mask[c])) begin
                lvl[c] = 1'b0;
            end
            s_d.pin_o[c] = lvl[c] ^ (enhanced_feature_enable & polarity[c]);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign count_value = s_q.cnt;
    assign ch_flag = s_q.chf;
    assign ovf_flag = s_q.ovf;
    assign fault_flag = s_q.fltf;
    assign protect_active = s_q.wp;
    assign channel_pin_o = s_q.pin_o;
    assign channel_pin_oe = s_q.pin_oe;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_at_top;
        tick_w && s_q.updown && s_q.dir == mpt_pkg::DIR_UP && s_q.cnt == fin_w;
    endsequence
    sequence s_turn_down;
        s_q.dir == mpt_pkg::DIR_DOWN ##0 count_value == $past(count_value) - 16'h0001;
    endsequence

    a_reload_init_ovf: assert property (
        (tick_w && !s_q.updown && s_q.cnt == fin_w) |=> (count_value == $past(ini_w)) && ovf_flag)
        else $error("final value did not reload the initial value");
    a_updown_turn_dir: assert property (
        s_at_top |=> s_turn_down)
        else $error("up-down counter failed to turn at the final value");
    a_debug_hold_count: assert property (
        debug_halt |=> $stable(count_value))
        else $error("counter moved during debug halt");
    a_fault_safe_out: assert property (
        (enhanced_feature_enable && s_q.flat && s_q.pfen[0]) |=>
        channel_pin_o[0] == $past(polarity[0]))
        else $error("faulted pair not at safe level");
    a_capture_dir_in: assert property (
        (s_q.mode[0] == mpt_pkg::MODE_CAPT && !enhanced_feature_enable) |=> !channel_pin_oe[0])
        else $error("capture channel drives its pin");
    a_protect_cfg_hold: assert property (
        (s_q.wp && crit_write) |=> $stable(s_q.mode) && $stable(s_q.updown))
        else $error("protected configuration changed");
    a_buffer_sync_load: assert property (
        !load_w |=> $stable(s_q.val_a) && $stable(s_q.fin_a))
        else $error("active value changed without sync");
    a_flag_set_wins: assert property (
        (ovf_set_w && ovf_clr) |=> ovf_flag)
        else $error("overflow lost against clear");
    a_enh_off_plain: assert property (
        (!enhanced_feature_enable ##1 !enhanced_feature_enable) |->
        channel_pin_o[1] == $past(raw_w[1]))
        else $error("enhanced shaping active while disabled");
endmodule // mpt_motor_pwm_timer

// ===== dv/mpt_far_side.sv
`timescale 1ns/1ns
module mpt_far_side (
    // Clock
    input wire logic clk_sys,
    // Bench levels
    input wire logic [7:0] drv,
    input wire logic [3:0] flt,
    // Device pins
    input wire logic [7:0] channel_pin_o,
    input wire logic [7:0] channel_pin_oe,
    output logic ext_count_clock,
    output logic fixed_freq_tick,
    output logic [7:0] channel_pin_i,
    output logic [3:0] fault_input
);
    logic [2:0] ph = 3'h0;
    always @(posedge clk_sys) ph <= ph + 3'h1;
    assign ext_count_clock = ph[1];
    assign fixed_freq_tick = (ph == 3'h7);
    assign channel_pin_i = (channel_pin_oe & channel_pin_o) | (~channel_pin_oe & drv);
    assign fault_input = flt;
endmodule // mpt_far_side

// ===== dv/mpt_motor_pwm_timer_tb.sv
`timescale 1ns/1ns
module mpt_motor_pwm_timer_tb;
    typedef struct packed {logic [1:0] src; logic [2:0] ps; logic [1:0] hs; logic [15:0] d;} mpt_row_t;
    logic clk_sys, reset;
    logic [1:0] clock_source_select, fault_handling_mode;
    logic [2:0] prescale_select;
    logic debug_halt, stop_mode, crit_write, protect_set, protect_clear, up_down_count, free_run;
    logic buf_write, sync_trigger, pwm_reload_control, enhanced_feature_enable, ovf_clr, fault_clr;
    logic [7:0][1:0] ch_mode, ch_edge;
    logic [3:0] pair_link_control, pair_complement, pair_deadtime_en, pair_fault_enable;
    logic [3:0] fault_input_enable, filter_len, flt, fault_input;
    logic [5:0] deadtime_cycles;
    logic [15:0] counter_initial_value, final_value, count_value, c0;
    logic [7:0][15:0] ch_value, capture_value;
    logic [7:0] polarity, output_mask, force_en, force_val, filter_en, ch_flag_clr, ch_flag, drv;
    logic [7:0] channel_pin_o, channel_pin_oe, channel_pin_i;
    logic ovf_flag, fault_flag, protect_active, ext_count_clock, fixed_freq_tick;
    int num_errors = 0;
    int n_compared = 0;
    // Source, prescale, halt and stop against ticks seen in 256 cycles
    mpt_row_t rows [11] = '{{2'h1, 3'h0, 2'h0, 16'h0100}, {2'h1, 3'h7, 2'h0, 16'h0002},
        {2'h1, 3'h3, 2'h0, 16'h0020}, {2'h2, 3'h0, 2'h0, 16'h0020}, {2'h2, 3'h2, 2'h0, 16'h0008},
        {2'h3, 3'h0, 2'h0, 16'h0040}, {2'h3, 3'h1, 2'h0, 16'h0020}, {2'h1, 3'h1, 2'h0, 16'h0080},
        {2'h0, 3'h0, 2'h0, 16'h0000},
        {2'h1, 3'h0, 2'h2, 16'h0000}, {2'h1, 3'h0, 2'h1, 16'h0000}};
    mpt_motor_pwm_timer dut (.clk_sys, .reset, .clock_source_select, .fixed_freq_tick,
        .ext_count_clock, .prescale_select, .debug_halt, .stop_mode, .crit_write, .protect_set,
        .protect_clear, .up_down_count, .free_run, .ch_mode, .ch_edge, .pair_link_control,
        .pair_complement, .pair_deadtime_en, .deadtime_cycles, .pair_fault_enable,
        .fault_handling_mode, .fault_input_enable, .buf_write, .counter_initial_value,
        .final_value, .ch_value, .sync_trigger, .pwm_reload_control, .enhanced_feature_enable,
        .polarity, .output_mask, .force_en, .force_val, .filter_en, .filter_len, .ch_flag_clr,
        .ovf_clr, .fault_clr, .ch_flag, .ovf_flag, .fault_flag, .protect_active, .channel_pin_i,
        .channel_pin_o, .channel_pin_oe, .fault_input, .count_value, .capture_value);
    mpt_far_side far (.clk_sys, .drv, .flt, .channel_pin_o, .channel_pin_oe, .ext_count_clock,
        .fixed_freq_tick, .channel_pin_i, .fault_input);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic crit();
        crit_write <= 1'b1;
        cyc(1);
        crit_write <= 1'b0;
        cyc(1);
    endtask
    task automatic wait_cnt(input logic [15:0] v);
        int k;
        for (k = 0; k < 64 && count_value !== v; k++) cyc(1);
        if (k == 64) begin
            num_errors++;
            conclude();
        end
    endtask
    initial begin
        reset <= 1'b1;
        {clock_source_select, fault_handling_mode, prescale_select, debug_halt, stop_mode,
            crit_write, protect_set, protect_clear, up_down_count, free_run, buf_write,
            sync_trigger, pwm_reload_control, enhanced_feature_enable, ovf_clr, fault_clr,
            ch_mode, ch_edge, pair_link_control, pair_complement, pair_deadtime_en,
            pair_fault_enable, fault_input_enable, filter_len, flt, deadtime_cycles,
            counter_initial_value, final_value, ch_value, polarity, output_mask, force_en,
            force_val, filter_en, ch_flag_clr, drv} <= '0;
        cyc(16);
        reset <= 1'b0;
        cyc(2);
        chk(count_value, 16'h0000);
        chk({ovf_flag, fault_flag, protect_active, channel_pin_oe}, 16'h0000);
        done("reset");
        ch_mode <= 16'h0024;
        ch_edge <= 16'h000D;
        ch_value[1] <= 16'h0001;
        final_value <= 16'h0002;
        crit();
        // Buffered values are written and synced with enhancements on, then enhancements go off
        enhanced_feature_enable <= 1'b1;
        buf_write <= 1'b1;
        cyc(1);
        buf_write <= 1'b0;
        sync_trigger <= 1'b1;
        cyc(1);
        sync_trigger <= 1'b0;
        enhanced_feature_enable <= 1'b0;
        clock_source_select <= mpt_pkg::SRC_SYS;
        wait_cnt(16'h0002);
        cyc(1);
        chk(count_value, 16'h0000);
        chk(ovf_flag, 1'b1);
        c0[0] = channel_pin_o[1];
        cyc(3);
        chk(channel_pin_o[1], !c0[0]);
        chk(channel_pin_oe, 8'h06);
        clock_source_select <= mpt_pkg::SRC_NONE;
        cyc(3);
        ovf_clr <= 1'b1;
        cyc(1);
        ovf_clr <= 1'b0;
        cyc(2);
        chk(ovf_flag, 1'b0);
        done("wrap");
        drv[0] <= 1'b1;
        cyc(4);
        chk(ch_flag[0], 1'b1);
        chk(capture_value[0], 16'h0001);
        ch_flag_clr[0] <= 1'b1;
        cyc(1);
        ch_flag_clr[0] <= 1'b0;
        drv[0] <= 1'b0;
        cyc(4);
        chk(ch_flag[0], 1'b0);
        done("capture");
        force_en[2] <= 1'b1;
        force_val[2] <= 1'b1;
        flt[1] <= 1'b1;
        cyc(4);
        chk({channel_pin_o[2], fault_flag}, 2'h0);
        enhanced_feature_enable <= 1'b1;
        cyc(4);
        chk({channel_pin_o[2], fault_flag}, 2'h2);
        fault_input_enable[1] <= 1'b1;
        pair_fault_enable[1:0] <= 2'h3;
        fault_handling_mode <= mpt_pkg::FLT_AUTO;
        crit();
        cyc(3);
        chk({channel_pin_o[2], fault_flag}, 2'h1);
        flt[1] <= 1'b0;
        fault_clr <= 1'b1;
        cyc(1);
        fault_clr <= 1'b0;
        cyc(4);
        chk({channel_pin_o[2], fault_flag}, 2'h2);
        output_mask[2] <= 1'b1;
        cyc(4);
        chk(channel_pin_o[2], 1'b0);
        done("fault");
        protect_set <= 1'b1;
        cyc(1);
        protect_set <= 1'b0;
        ch_mode <= 16'h0000;
        crit();
        chk({protect_active, channel_pin_oe}, 16'h0106);
        protect_clear <= 1'b1;
        cyc(1);
        protect_clear <= 1'b0;
        free_run <= 1'b1;
        crit();
        cyc(1);
        chk({protect_active, channel_pin_oe}, 16'h0000);
        done("protect");
        // Windows hold whole prescaler periods, so the tick phase does not matter
        foreach (rows[i]) begin
            {clock_source_select, prescale_select, debug_halt, stop_mode} <= rows[i][22:16];
            cyc(8);
            c0 = count_value;
            cyc(256);
            chk(count_value - c0, rows[i].d);
        end
        done("rates");
        reset <= 1'b1;
        cyc(2);
        reset <= 1'b0;
        cyc(2);
        chk({protect_active, ovf_flag, fault_flag, channel_pin_oe}, 16'h0000);
        chk(count_value, 16'h0000);
        done("second reset");
        // Up-down between 0 and 2, with pair 0 combined and complementary
        up_down_count <= 1'b1;
        free_run <= 1'b0;
        pair_link_control <= 4'h1;
        pair_complement <= 4'h1;
        ovf_clr <= 1'b1;
        buf_write <= 1'b1;
        crit();
        buf_write <= 1'b0;
        sync_trigger <= 1'b1;
        cyc(1);
        sync_trigger <= 1'b0;
        stop_mode <= 1'b0;
        cyc(4);
        chk(count_value, 16'h0001);
        chk(ovf_flag, 1'b1);
        cyc(2);
        chk({ovf_flag, channel_pin_oe[1:0], channel_pin_o[1:0]}, 16'h000D);
        ovf_clr <= 1'b0;
        done("up-down");
        conclude();
    end
endmodule // mpt_motor_pwm_timer_tb
